// file: src/vic_regs.vh
// Register map, reset values, vectors and codes of the vectored interrupt controller
// Functional notes
// (RULE_01) Watchdog mode 1 overflow: non-maskable, vector 0004H
// (RULE_02) Any pending request raises standby release; the code raises it only for the NMI or an unmasked pending request
// (RULE_03) Lowest priority number wins among maskables
// (RULE_04) Pins 0-2: priorities 1-3, vectors 0006H-000AH
// (RULE_05) Serial receive/transfer share flag; transmit priority 5
// (RULE_06) Timers priorities 6,7; key-return 8, vectors fixed
// (RULE_07) Interval-mode watchdog overflow is maskable priority 0
// (RULE_08) Flags set by event/write, cleared by ack/write
// (RULE_09) Flag bit layout across two flag registers
// (RULE_10) Software writes zero to unused flag bits
// (RULE_11) Watchdog flag accessible only in interval mode
// (RULE_12) Mask 1 blocks servicing; masks reset to FFH
// (RULE_13) Software writes one to unused mask bits
// (RULE_14) Watchdog mask read undefined in watchdog modes
// (RULE_15) Two-bit edge codes per pin; 10 prohibited
// (RULE_16) Output-mode level change on pin sets flag
// (RULE_17) Mask, change edge, clear flag, then unmask
// (RULE_18) Enable bit in status bit 7, cleared on acceptance
// (RULE_19) Key select: bit0 group 0-3, bits 4-7 single
// (RULE_20) Selected key pin falling edge raises key request
// (RULE_21) Selected key pin gets pull-up unless output
// (RULE_22) Mask key source before changing key selection
// (RULE_23) Maskable accepted only with flag, unmasked, enabled
// (RULE_24) Acceptance held while flag/mask registers accessed
// (RULE_25) Inputs synchronised; one flag set per edge
// (RULE_26) Valid plus vector to core; ack clears flag
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

`define ADDR_REQ_LO       16'hFFE0
`define ADDR_REQ_HI       16'hFFE1
`define ADDR_MASK_LO      16'hFFE4
`define ADDR_MASK_HI      16'hFFE5
`define ADDR_EDGE_SEL     16'hFFEC
`define ADDR_KEY_SEL      16'hFFF5

`define RST_REQ           8'h00
`define RST_MASK          8'hFF
`define RST_EDGE_SEL      8'h00
`define RST_KEY_SEL       8'h00
`define RST_PSW           8'h02
`define PSW_IE_BIT        7

// Source indices equal maskable priority numbers
`define SRC_WDT           4'h0
`define SRC_PIN0          4'h1
`define SRC_PIN1          4'h2
`define SRC_PIN2          4'h3
`define SRC_SRX           4'h4
`define SRC_STX           4'h5
`define SRC_TM8           4'h6
`define SRC_TM16          4'h7
`define SRC_KEY           4'h8
`define SRC_NMI           4'h9
`define NUM_SRC           9

`define VEC_NMI           16'h0004
`define VEC_PIN0          16'h0006
`define VEC_PIN1          16'h0008
`define VEC_PIN2          16'h000A
`define VEC_SRX           16'h000C
`define VEC_STX           16'h000E
`define VEC_TM8           16'h0010
`define VEC_TM16          16'h0014
`define VEC_KEY           16'h002A
// Interval-mode watchdog vector (not printed with the maskable row)
`define VEC_WDT_INT       16'h0004

`define WDT_MODE_INTERVAL 2'b00
`define WDT_MODE_1        2'b01
`define WDT_MODE_2        2'b10

`define EDGE_FALL         2'b00
`define EDGE_RISE         2'b01
`define EDGE_BOTH         2'b11

// Low-register layout: bits 6:0 hold sources 0..6; high register bit 7 timer16, bit 0 key
`define LO_SRC_MSB        6
`define HI_TM16_BIT       7
`define HI_KEY_BIT        0

`endif

// file: src/sync_edge.v
// Two-flop synchroniser with per-bit rising/falling edge detection
`timescale 1ns/100ps
module sync_edge #(
	parameter WIDTH = 3
) (
	input  wire             sys_clk_in,   // System clock
	input  wire             rst_in,       // Synchronous reset, active high
	input  wire [WIDTH-1:0] sig_in,       // Raw pin levels
	input  wire [WIDTH-1:0] rise_sel_in,  // Detect rising edge per bit
	input  wire [WIDTH-1:0] fall_sel_in,  // Detect falling edge per bit
	output wire [WIDTH-1:0] edge_out      // One-cycle pulse per detected edge
);
	reg [WIDTH-1:0] meta;
	reg [WIDTH-1:0] stable;
	reg [WIDTH-1:0] prev;

	// Only the second and third stages feed the edge compare
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta   <= {WIDTH{1'b0}};
			stable <= {WIDTH{1'b0}};
			prev   <= {WIDTH{1'b0}};
		end else begin
			meta   <= sig_in;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign edge_out = (stable & ~prev & rise_sel_in) | (~stable & prev & fall_sel_in); // RULE_25
endmodule // sync_edge

// file: src/prio_resolve.v
// Fixed-priority resolver returning winning source index and vector
`timescale 1ns/100ps
`include "vic_regs.vh"
module prio_resolve (
	input  wire [8:0]  active_in,   // Requests that may be accepted, by priority index
	input  wire        nmi_in,      // Non-maskable request pending
	output reg         found_out,   // Some request wins
	output reg  [3:0]  idx_out,     // Winning source index
	output wire [15:0] vector_out   // Vector address of the winner
);
	integer i;

	function [15:0] vec_of;
		input [3:0] idx;
		begin
			case (idx)
				`SRC_WDT:  vec_of = `VEC_WDT_INT;
				`SRC_PIN0: vec_of = `VEC_PIN0;  // RULE_04
				`SRC_PIN1: vec_of = `VEC_PIN1;
				`SRC_PIN2: vec_of = `VEC_PIN2;
				`SRC_SRX:  vec_of = `VEC_SRX;   // RULE_05
				`SRC_STX:  vec_of = `VEC_STX;
				`SRC_TM8:  vec_of = `VEC_TM8;   // RULE_06
				`SRC_TM16: vec_of = `VEC_TM16;
				`SRC_KEY:  vec_of = `VEC_KEY;
				default:   vec_of = `VEC_NMI;   // RULE_01
			endcase
		end
	endfunction

	always @* begin
		found_out = 1'b0;
		idx_out   = `SRC_NMI;
		if (nmi_in) begin
			found_out = 1'b1;  // RULE_01
		end else begin
			// Scan downward so the lowest index is the last to land
			for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
				if (active_in[i]) begin
					found_out = 1'b1;
					idx_out   = i[3:0];  // RULE_03
				end
			end
		end
	end

	assign vector_out = vec_of(idx_out);
endmodule // prio_resolve

// file: src/vectored_interrupt_controller.v
// Vectored interrupt controller: flags, masks, edge and key detection, priority, vectors
`timescale 1ns/100ps
`include "vic_regs.vh"
module vectored_interrupt_controller (
	input  wire        sys_clk_in,              // System clock, 20 MHz
	input  wire        rst_in,                  // Synchronous reset, active high
	input  wire [15:0] reg_addr_in,             // Memory-instruction address
	input  wire        reg_wr_in,               // Write strobe
	input  wire        reg_rd_in,               // Read strobe
	input  wire [7:0]  reg_wdata_in,            // Write data
	output reg  [7:0]  reg_rdata_out,           // Read data, held until next read
	input  wire        psw_load_in,             // Core loads status word
	input  wire [7:0]  psw_wdata_in,            // Status word value to load
	output reg  [7:0]  psw_out,                 // Status word
	input  wire [1:0]  wdt_mode_in,             // Watchdog operating mode
	input  wire        watchdog_irq_in,         // Watchdog overflow pulse
	input  wire        uart_rx_done_irq_in,     // UART receive complete pulse
	input  wire        sync_xfer_done_irq_in,   // Synchronous transfer complete pulse
	input  wire        uart_tx_done_irq_in,     // UART transmit complete pulse
	input  wire        timer8_match_irq_in,     // 8-bit timer match pulse
	input  wire        timer16_match_irq_in,    // 16-bit timer match pulse
	input  wire [2:0]  pin_in,                  // External request pin levels
	input  wire [7:0]  key_in,                  // Key-return pin levels
	input  wire [7:0]  key_pin_output_in,       // Key pin is in output mode
	output reg  [7:0]  key_pullup_en_out,       // Pull-up enable per key pin
	input  wire        irq_ack_in,              // Core accepts the presented request
	output reg         irq_valid_out,           // Request presented to core
	output reg  [15:0] irq_vector_out,          // Vector of presented request
	output reg         irq_nmi_out,             // Presented request is non-maskable
	output reg         standby_release_out      // Wake halted or stopped core
);
	////////////////////////////////////////////////////////////////
	reg  [8:0]  req_flag;
	reg  [8:0]  mask_flag;
	reg         nmi_pend;
	reg  [7:0]  pin_edge_select;
	reg  [7:0]  key_pin_select;
	reg  [3:0]  shown_idx;

	reg  [8:0]  next_req_flag;
	reg  [8:0]  next_mask_flag;
	reg  [8:0]  event_set;
	reg  [8:0]  ack_clr;
	reg  [7:0]  next_rdata;

	wire        interval_mode = (wdt_mode_in == `WDT_MODE_INTERVAL);
	wire        ie            = psw_out[`PSW_IE_BIT];
	wire        acc_any       = reg_wr_in | reg_rd_in;
	wire        hit_req_lo    = acc_any & (reg_addr_in == `ADDR_REQ_LO);
	wire        hit_req_hi    = acc_any & (reg_addr_in == `ADDR_REQ_HI);
	wire        hit_mask_lo   = acc_any & (reg_addr_in == `ADDR_MASK_LO);
	wire        hit_mask_hi   = acc_any & (reg_addr_in == `ADDR_MASK_HI);
	wire        flag_access   = hit_req_lo | hit_req_hi | hit_mask_lo | hit_mask_hi;
	wire        wr_req_lo     = reg_wr_in & hit_req_lo;
	wire        wr_req_hi     = reg_wr_in & hit_req_hi;
	wire        wr_mask_lo    = reg_wr_in & hit_mask_lo;
	wire        wr_mask_hi    = reg_wr_in & hit_mask_hi;
	wire        wr_edge       = reg_wr_in & (reg_addr_in == `ADDR_EDGE_SEL);
	wire        wr_key        = reg_wr_in & (reg_addr_in == `ADDR_KEY_SEL);

	////////////////////////////////////////////////////////////////
	// Edge selection decode per pin; code 10 detects nothing
	function [1:0] edge_dec;  // {rise, fall}
		input [1:0] code;
		begin
			case (code)
				`EDGE_FALL: edge_dec = 2'b01;
				`EDGE_RISE: edge_dec = 2'b10;
				`EDGE_BOTH: edge_dec = 2'b11;
				default:    edge_dec = 2'b00;
			endcase
		end
	endfunction

	wire [1:0] pin0_sel = edge_dec(pin_edge_select[3:2]);  // RULE_15
	wire [1:0] pin1_sel = edge_dec(pin_edge_select[5:4]);
	wire [1:0] pin2_sel = edge_dec(pin_edge_select[7:6]);
	wire [2:0] pin_edge;
	wire [7:0] key_edge;
	wire [7:0] key_enable = {key_pin_select[7:4], {4{key_pin_select[0]}}};  // RULE_19

	// Pad level is sampled even in output mode, so driven changes set flags
	sync_edge #(.WIDTH(3)) u_pin_edge (  // RULE_16
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sig_in      (pin_in),
		.rise_sel_in ({pin2_sel[1], pin1_sel[1], pin0_sel[1]}),
		.fall_sel_in ({pin2_sel[0], pin1_sel[0], pin0_sel[0]}),
		.edge_out    (pin_edge)
	);

	sync_edge #(.WIDTH(8)) u_key_edge (  // RULE_20
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sig_in      (key_in),
		.rise_sel_in (8'h00),
		.fall_sel_in (key_enable),
		.edge_out    (key_edge)
	);

	////////////////////////////////////////////////////////////////
	// Priority resolution
	wire [8:0]  active = req_flag & ~mask_flag & {9{ie}};  // RULE_23
	wire        win_found;
	wire [3:0]  win_idx;
	wire [15:0] win_vector;

	prio_resolve u_prio (
		.active_in  (active),
		.nmi_in     (nmi_pend),
		.found_out  (win_found),
		.idx_out    (win_idx),
		.vector_out (win_vector)
	);

	////////////////////////////////////////////////////////////////
	// Flag and mask next values: event set beats ack or write clear
	always @* begin
		event_set            = 9'h000;
		event_set[`SRC_WDT]  = watchdog_irq_in & interval_mode;  // RULE_07
		event_set[`SRC_PIN0] = pin_edge[0];                      // RULE_04
		event_set[`SRC_PIN1] = pin_edge[1];
		event_set[`SRC_PIN2] = pin_edge[2];
		event_set[`SRC_SRX]  = uart_rx_done_irq_in | sync_xfer_done_irq_in;  // RULE_05
		event_set[`SRC_STX]  = uart_tx_done_irq_in;
		event_set[`SRC_TM8]  = timer8_match_irq_in;              // RULE_06
		event_set[`SRC_TM16] = timer16_match_irq_in;
		event_set[`SRC_KEY]  = |key_edge;                        // RULE_20

		ack_clr = 9'h000;
		if (irq_ack_in & irq_valid_out & ~irq_nmi_out) begin
			ack_clr[shown_idx] = 1'b1;  // RULE_26
		end

		next_req_flag = req_flag;
		if (wr_req_lo) begin
			next_req_flag[`LO_SRC_MSB:0] = reg_wdata_in[`LO_SRC_MSB:0];  // RULE_09
			if (!interval_mode) begin
				next_req_flag[`SRC_WDT] = 1'b0;  // RULE_11
			end
		end
		if (wr_req_hi) begin
			next_req_flag[`SRC_TM16] = reg_wdata_in[`HI_TM16_BIT];
			next_req_flag[`SRC_KEY]  = reg_wdata_in[`HI_KEY_BIT];
		end
		next_req_flag = (next_req_flag & ~ack_clr) | event_set;  // RULE_08

		next_mask_flag = mask_flag;
		if (wr_mask_lo) begin
			next_mask_flag[`LO_SRC_MSB:0] = reg_wdata_in[`LO_SRC_MSB:0];  // RULE_12
		end
		if (wr_mask_hi) begin
			next_mask_flag[`SRC_TM16] = reg_wdata_in[`HI_TM16_BIT];
			next_mask_flag[`SRC_KEY]  = reg_wdata_in[`HI_KEY_BIT];
		end
	end

	// Read mux; unused flag bits read 0, unused mask bits read 1
	always @* begin
		case (reg_addr_in)
			`ADDR_REQ_LO:   next_rdata = {1'b0, req_flag[`LO_SRC_MSB:1], req_flag[`SRC_WDT] & interval_mode};  // RULE_11
			`ADDR_REQ_HI:   next_rdata = {req_flag[`SRC_TM16], 6'b00_0000, req_flag[`SRC_KEY]};
			// Watchdog mask reads back as stored; undefined in watchdog modes anyway
			`ADDR_MASK_LO:  next_rdata = {1'b1, mask_flag[`LO_SRC_MSB:0]};  // RULE_14
			`ADDR_MASK_HI:  next_rdata = {mask_flag[`SRC_TM16], 6'b11_1111, mask_flag[`SRC_KEY]};
			`ADDR_EDGE_SEL: next_rdata = pin_edge_select;
			`ADDR_KEY_SEL:  next_rdata = key_pin_select;
			default:        next_rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			req_flag        <= {`NUM_SRC{1'b0}};  // RULE_08
			mask_flag       <= {`NUM_SRC{1'b1}};  // RULE_12
			nmi_pend        <= 1'b0;
			pin_edge_select <= `RST_EDGE_SEL;
			key_pin_select  <= `RST_KEY_SEL;
			reg_rdata_out   <= 8'h00;
			psw_out         <= `RST_PSW;          // RULE_18
		end else begin
			req_flag  <= next_req_flag;
			mask_flag <= next_mask_flag;
			// Overflow in mode 1 is non-maskable; set beats the ack clear
			if (watchdog_irq_in && wdt_mode_in == `WDT_MODE_1) begin
				nmi_pend <= 1'b1;  // RULE_01
			end else if (irq_ack_in & irq_valid_out & irq_nmi_out) begin
				nmi_pend <= 1'b0;
			end
			if (wr_edge) begin
				pin_edge_select <= {reg_wdata_in[7:2], 2'b00};  // RULE_15
			end
			if (wr_key) begin
				key_pin_select <= {reg_wdata_in[7:4], 3'b000, reg_wdata_in[0]};  // RULE_19
			end
			if (reg_rd_in) begin
				reg_rdata_out <= next_rdata;
			end
			// Acceptance clears the enable bit after any core load
			if (psw_load_in) begin
				psw_out <= psw_wdata_in;
			end
			if (irq_ack_in & irq_valid_out) begin
				psw_out[`PSW_IE_BIT] <= 1'b0;  // RULE_18
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Presented request; cleared the cycle after ack so a stale winner never repeats
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			irq_valid_out       <= 1'b0;
			irq_vector_out      <= `VEC_NMI;
			irq_nmi_out         <= 1'b0;
			shown_idx           <= `SRC_NMI;
			standby_release_out <= 1'b0;
			key_pullup_en_out   <= 8'h00;
		end else begin
			irq_valid_out       <= win_found & ~flag_access & ~irq_ack_in;  // RULE_24
			irq_vector_out      <= win_vector;                              // RULE_26
			irq_nmi_out         <= nmi_pend;
			shown_idx           <= win_idx;
			standby_release_out <= nmi_pend | (|(req_flag & ~mask_flag));  // RULE_02
			key_pullup_en_out   <= key_enable & ~key_pin_output_in;        // RULE_21
		end
	end
endmodule // vectored_interrupt_controller

// file: tb/cpu_core_model.sv
// Core-side partner: acknowledges presented requests after a set delay
`timescale 1ns/100ps
module cpu_core_model (
	input  wire        sys_clk_in,       // Clock
	input  wire        rst_in,           // Reset
	input  wire [3:0]  ack_delay_in,     // Wait cycles before ack
	input  wire        irq_valid_in,     // Request presented
	input  wire [15:0] irq_vector_in,    // Presented vector
	input  wire        irq_nmi_in,       // Presented is NMI
	output reg         irq_ack_out,      // Ack pulse
	output reg  [15:0] taken_vector_out, // Last vector taken
	output reg         taken_nmi_out,    // Last NMI taken
	output reg  [7:0]  taken_count_out   // Acks given
);
	reg [3:0] wait_cnt;

	// One-cycle ack; it drops after one edge so a request is never taken twice
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			irq_ack_out <= 1'b0;
			wait_cnt <= 4'h0;
			taken_count_out <= 8'h00;
		end else if (irq_ack_out | ~irq_valid_in) begin
			irq_ack_out <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (wait_cnt == ack_delay_in) begin
			irq_ack_out <= 1'b1;
			taken_vector_out <= irq_vector_in;
			taken_nmi_out <= irq_nmi_in;
			taken_count_out <= taken_count_out + 8'h01;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // cpu_core_model

// file: tb/vic_checker.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/100ps
module vic_checker (
	input wire        sys_clk_in,         // Clock
	input wire        rst_in,             // Reset
	input wire [15:0] reg_addr_in,        // Address
	input wire        reg_wr_in,          // Write
	input wire        reg_rd_in,          // Read
	input wire        psw_load_in,        // Status load
	input wire [7:0]  psw_out,            // Status word
	input wire [7:0]  key_pin_output_in,  // Key output mode
	input wire [7:0]  key_pullup_en_out,  // Pull-ups
	input wire        irq_ack_in,         // Ack
	input wire        irq_valid_out,      // Valid
	input wire [15:0] irq_vector_out,     // Vector
	input wire        irq_nmi_out,        // NMI
	input wire        standby_release_out // Wake
);
	// Access to either flag or mask register
	wire flag_acc = (reg_wr_in | reg_rd_in) & (reg_addr_in[15:3] == 13'h1ffc) & ~reg_addr_in[1];

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_reset_state: assert property (disable iff (1'b0) rst_in |=> psw_out == 8'h02 && !irq_valid_out)
		else $error("reset state wrong");
	a_ack_retires_req: assert property (irq_valid_out && irq_ack_in |=> !irq_valid_out && !psw_out[7])
		else $error("ack did not retire request");
	a_access_holds: assert property (flag_acc |=> !irq_valid_out)
		else $error("request shown during flag access");
	a_nmi_vector: assert property (irq_valid_out && irq_nmi_out |-> irq_vector_out == 16'h0004)
		else $error("nmi vector wrong");
	a_req_stands: assert property (irq_valid_out && !irq_ack_in && !flag_acc && !psw_load_in
		|=> irq_valid_out && $stable(irq_vector_out))
		else $error("request dropped before ack");
	a_ie_gates: assert property ($rose(irq_valid_out) && !irq_nmi_out |-> $past(psw_out[7]))
		else $error("maskable shown with enable off");
	a_pullup_output: assert property ((key_pullup_en_out & $past(key_pin_output_in)) == 8'h00)
		else $error("pull-up on output pin");
	a_wake_on_req: assert property (irq_valid_out |-> standby_release_out)
		else $error("no standby release");
endmodule // vic_checker

bind vectored_interrupt_controller vic_checker i_chk (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
	.reg_rd_in, .psw_load_in, .psw_out, .key_pin_output_in, .key_pullup_en_out, .irq_ack_in,
	.irq_valid_out, .irq_vector_out, .irq_nmi_out, .standby_release_out);

// file: tb/vectored_interrupt_controller_tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module vectored_interrupt_controller_tb_top;
	logic        sys_clk_in = 1'b0, rst_in = 1'b1;
	logic [15:0] reg_addr_in = 16'h0000;
	logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, psw_load_in = 1'b0;
	logic [7:0]  reg_wdata_in = 8'h00, psw_wdata_in = 8'h00;
	logic [1:0]  wdt_mode_in = 2'b00;
	logic [5:0]  src = 6'h00;
	logic [2:0]  pin_in = 3'h0;
	logic [7:0]  key_in = 8'hff, key_pin_output_in = 8'h02;
	logic [7:0]  reg_rdata_out, psw_out, key_pullup_en_out, taken_count;
	logic        irq_ack_in, irq_valid_out, irq_nmi_out, standby_release_out, taken_nmi;
	logic [15:0] irq_vector_out, taken_vector;
	logic [3:0]  ack_delay = 4'h0;
	int          n_fail = 0, compares = 0, cycles = 0;
	wire         watchdog_irq_in, uart_rx_done_irq_in, sync_xfer_done_irq_in;
	wire         uart_tx_done_irq_in, timer8_match_irq_in, timer16_match_irq_in;

	assign {watchdog_irq_in, uart_rx_done_irq_in, sync_xfer_done_irq_in,
		uart_tx_done_irq_in, timer8_match_irq_in, timer16_match_irq_in} = src;

	vectored_interrupt_controller i_dut (.*);
	cpu_core_model i_core (.sys_clk_in, .rst_in, .ack_delay_in(ack_delay), .irq_valid_in(irq_valid_out),
		.irq_vector_in(irq_vector_out), .irq_nmi_in(irq_nmi_out), .irq_ack_out(irq_ack_in),
		.taken_vector_out(taken_vector), .taken_nmi_out(taken_nmi), .taken_count_out(taken_count));

	initial forever #25 sys_clk_in = ~sys_clk_in;

	// Run takes about 210 cycles; the ceiling leaves ample room
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////
	task tally_and_finish();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk("rdata", e, reg_rdata_out);
	endtask

	task pulse(input logic [5:0] s);
		@(posedge sys_clk_in);
		src <= s;
		@(posedge sys_clk_in);
		src <= 6'h00;
	endtask

	// Pad change; edges need three synchroniser edges before the flag shows
	task pads(input logic [2:0] p, input logic [7:0] k);
		@(posedge sys_clk_in);
		pin_in <= p;
		key_in <= k;
		tick(5);
	endtask

	task set_ie(input logic ie);
		@(posedge sys_clk_in);
		psw_load_in <= 1'b1;
		psw_wdata_in <= ie ? 8'h82 : 8'h02;
		@(posedge sys_clk_in);
		psw_load_in <= 1'b0;
	endtask

	// Acceptance clears the enable, so it is reloaded from ie before each wait
	task serve(input logic [15:0] v, input logic nmi, input logic ie);
		int n;
		logic [7:0] c0;
		c0 = taken_count;
		set_ie(ie);
		n = 0;
		while (taken_count === c0 && n < 40) begin
			@(posedge sys_clk_in);
			n++;
		end
		chk("served", c0 + 8'h01, taken_count);
		chk("vector", v, taken_vector);
		chk("nmi", nmi, taken_nmi);
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset();
		rd(16'hffe0, 8'h00);
		rd(16'hffe1, 8'h00);
		rd(16'hffe4, 8'hff);
		rd(16'hffe5, 8'hff);
		rd(16'hffec, 8'h00);
		rd(16'hfff5, 8'h00);
		rd(16'hffe2, 8'h00);
		chk("psw", 8'h02, psw_out);
		$display("test reset done");
	endtask

	task t_pins();
		wr(16'hffec, 8'hd0);
		rd(16'hffec, 8'hd0);
		pads(3'h7, 8'hff);
		rd(16'hffe0, 8'h0c);
		wr(16'hffe0, 8'h00);
		pads(3'h0, 8'hff);
		rd(16'hffe0, 8'h0a);
		wr(16'hffe0, 8'h00);
		wr(16'hffec, 8'h0b);
		rd(16'hffec, 8'h08);
		pads(3'h7, 8'hff);
		rd(16'hffe0, 8'h00);
		pads(3'h0, 8'hff);
		rd(16'hffe0, 8'h0c);
		wr(16'hffe0, 8'h0e);
		wr(16'hffe4, 8'h80);
		tick(3);
		#1 chk("valid", 1'b0, irq_valid_out);
		chk("standby", 1'b1, standby_release_out);
		rd(16'hffe4, 8'h80);
		serve(16'h0006, 1'b0, 1'b1);
		serve(16'h0008, 1'b0, 1'b1);
		serve(16'h000a, 1'b0, 1'b1);
		$display("test pins done");
	endtask

	task t_periph();
		wr(16'hffe5, 8'h7e);
		pulse(6'h17);
		rd(16'hffe0, 8'h70);
		rd(16'hffe1, 8'h80);
		serve(16'h000c, 1'b0, 1'b1);
		serve(16'h000e, 1'b0, 1'b1);
		serve(16'h0010, 1'b0, 1'b1);
		serve(16'h0014, 1'b0, 1'b1);
		pulse(6'h08);
		serve(16'h000c, 1'b0, 1'b1);
		$display("test periph done");
	endtask

	task t_keys();
		wr(16'hffe5, 8'h7f);
		wr(16'hfff5, 8'h1f);
		rd(16'hfff5, 8'h11);
		chk("pullup", 8'h1d, key_pullup_en_out);
		pads(3'h0, 8'hdf);
		rd(16'hffe1, 8'h00);
		pads(3'h0, 8'hdb);
		rd(16'hffe1, 8'h01);
		set_ie(1'b1);
		tick(3);
		#1 chk("valid", 1'b0, irq_valid_out);
		// Enable off again so the core cannot take the key request before serve counts
		set_ie(1'b0);
		pads(3'h0, 8'hff);
		wr(16'hffe1, 8'h00);
		wr(16'hffe5, 8'h7e);
		pads(3'h0, 8'hef);
		serve(16'h002a, 1'b0, 1'b1);
		$display("test keys done");
	endtask

	task t_watchdog();
		pulse(6'h22);
		serve(16'h0004, 1'b0, 1'b1);
		serve(16'h0010, 1'b0, 1'b1);
		wdt_mode_in <= 2'b01;
		wr(16'hffe0, 8'h01);
		rd(16'hffe0, 8'h00);
		wr(16'hffe4, 8'hff);
		ack_delay <= 4'h8;
		pulse(6'h20);
		tick(3);
		#1 chk("standby", 1'b1, standby_release_out);
		serve(16'h0004, 1'b1, 1'b0);
		// Mode 2 overflow raises neither a flag nor a non-maskable request
		wdt_mode_in <= 2'b10;
		pulse(6'h20);
		tick(3);
		#1 chk("standby", 1'b0, standby_release_out);
		rd(16'hffe0, 8'h00);
		$display("test watchdog done");
	endtask

	initial begin
		tick(4);
		rst_in <= 1'b0;
		t_reset();
		t_pins();
		t_periph();
		t_keys();
		t_watchdog();
		tally_and_finish();
	end
endmodule // vectored_interrupt_controller_tb_top
